// ---- design/acr_regs_pkg.sv ----
package acr_regs_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam int          ADDR_W            = 16;
  localparam logic [15:0] REPEAT_CTRL_ADDR  = 16'h21F0;
  localparam logic [15:0] UNLOCK_KEY_ADDR   = 16'h2230;
  localparam logic [15:0] BUFFER_CFG_ADDR   = 16'h238C;

  // Calibration pairs: 0 low power TIA, 1 fast TIA, 2 temperature sensor,
  // 3..7 auxiliary input at PGA gain 1, 1.5, 2, 4, 9
  localparam int          CAL_PAIRS         = 8;
  localparam logic [CAL_PAIRS-1:0][15:0] OFFSET_CAL_ADDR = {
    16'h22D0, 16'h22D4, 16'h22C8, 16'h22CC,
    16'h2244, 16'h223C, 16'h2234, 16'h2288};
  localparam logic [CAL_PAIRS-1:0][15:0] GAIN_CAL_ADDR = {
    16'h2298, 16'h2278, 16'h2274, 16'h2270,
    16'h2240, 16'h2238, 16'h2284, 16'h228C};
  localparam logic [2:0]  AUX_BASE_PAIR     = 3'h3;
  localparam logic [2:0]  AUX_GAIN_STEPS    = 3'h5;

  // ----------------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------------
  localparam int          REPEAT_EN_BIT     = 0;
  localparam int          REPEAT_CNT_LSB    = 4;
  localparam int          REPEAT_CNT_W      = 8;
  localparam int          CHOP_OFF_LSB      = 0;
  localparam int          CHOP_OFF_W        = 4;
  localparam int          POWER_DOWN_LSB    = 4;
  localparam int          POWER_DOWN_W      = 5;
  localparam int          CAL_W             = 15;
  localparam int          RESULT_W          = 16;
  // Gain is 1.14 fixed point and offset is in quarter LSBs
  localparam int          CORR_SHIFT        = 16;

  // ----------------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------------
  localparam logic [31:0] REPEAT_CTRL_RESET = 32'h0000_0160;
  localparam logic [31:0] BUFFER_CFG_RESET  = 32'h005F_3D00;
  localparam logic [31:0] UNLOCK_KEY_RESET  = 32'h0000_0000;
  localparam logic [31:0] UNLOCK_KEY_VALUE  = 32'hDE87_A5AF;
  localparam logic [14:0] OFFSET_CAL_RESET  = 15'h0000;
  localparam logic [14:0] GAIN_CAL_RESET    = 15'h4000;
  // Upper part of the buffer register is fixed and not writable
  localparam logic [31:0] BUFFER_CFG_FIXED  = 32'h005F_3C00;

endpackage : acr_regs_pkg

// ---- design/acr_regs.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Ctrl bit 0 turns repeated conversions on when set; resets to off.
// - Repeat control resets to 0x00000160, a repeat count of 0x16.
// - Buffer 8:4 power down offset cancel, ADC buf, PGA, FE pos, FE neg.
// - Buffer 3:0 turn chopping off: offset cancel, ADC buf, PGA, FE.
// - Buffer config resets to 0x005F3D00: power-down 0x10, chop-off 0.
// - A 32-bit key guards calibration; writing 0xDE87A5AF unlocks it.
// - Calibration is protected unless the key matches; key resets to 0.
// - Own pairs for low power TIA, fast TIA, temp; reset 0 and 0x4000.
// - Aux pair per PGA gain 1, 1.5, 2, 4, 9; the active one is used.
// - Offset is 15-bit two's complement in quarter LSBs; zero is none.
// - Gain: 15 bits, 0x4000 unity, 0x7FFF just under two, zero gives zero result.

module acr_regs (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  // Register port
  input  wire logic [15:0]                 regAddr,
  input  wire logic [31:0]                 regWriteData,
  input  wire logic                        regWrite,
  input  wire logic                        regRead,
  output logic      [31:0]                 regReadData,
  // Control outputs to the analog front end and sequencer
  output logic                             repeatEnable,
  output logic      [7:0]                  repeatCount,
  output logic      [4:0]                  stagePowerDown,
  output logic      [3:0]                  choppingOffBits,
  output logic                             calUnlocked,
  // Channel selection for calibration
  input  wire logic [1:0]                  channelSel,
  input  wire logic [2:0]                  auxGainSel,
  output logic      [14:0]                 activeOffset,
  output logic      [14:0]                 activeGain,
  // Raw conversion in, corrected conversion out
  input  wire logic [15:0]                 rawResult,
  input  wire logic                        rawValid,
  output logic      [15:0]                 conversionResult,
  output logic                             conversionValid
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                            repeatCount;
    logic                                  repeatEnable;
    logic [4:0]                            stagePowerDown;
    logic [3:0]                            choppingOffBits;
    logic [31:0]                           unlockKey;
    logic [acr_regs_pkg::CAL_PAIRS-1:0][14:0] offsetCal;
    logic [acr_regs_pkg::CAL_PAIRS-1:0][14:0] gainCal;
    logic [31:0]                           readData;
    logic [14:0]                           activeOffset;
    logic [14:0]                           activeGain;
    logic [15:0]                           result;
    logic                                  resultValid;
  } acr_state_t;

  acr_state_t state;
  acr_state_t next_state;
  acr_state_t resetState;

  logic              unlocked;
  logic [2:0]        pairSel;
  logic [2:0]        auxIndex;
  logic signed [18:0] sumVal;
  logic signed [34:0] productVal;
  logic signed [34:0] scaledVal;

  // ----------------------------------------------------------------------
  // Reset image
  // ----------------------------------------------------------------------
  always_comb begin
    resetState = '0;
    resetState.repeatCount = acr_regs_pkg::REPEAT_CTRL_RESET[
      acr_regs_pkg::REPEAT_CNT_LSB +: acr_regs_pkg::REPEAT_CNT_W];
    resetState.repeatEnable = acr_regs_pkg::REPEAT_CTRL_RESET[
      acr_regs_pkg::REPEAT_EN_BIT];
    resetState.stagePowerDown = acr_regs_pkg::BUFFER_CFG_RESET[
      acr_regs_pkg::POWER_DOWN_LSB +: acr_regs_pkg::POWER_DOWN_W];
    resetState.choppingOffBits = acr_regs_pkg::BUFFER_CFG_RESET[
      acr_regs_pkg::CHOP_OFF_LSB +: acr_regs_pkg::CHOP_OFF_W];
    resetState.unlockKey = acr_regs_pkg::UNLOCK_KEY_RESET;
    for (int i = 0; i < acr_regs_pkg::CAL_PAIRS; i++) begin
      resetState.offsetCal[i] = acr_regs_pkg::OFFSET_CAL_RESET;
      resetState.gainCal[i] = acr_regs_pkg::GAIN_CAL_RESET;
    end
    resetState.activeGain = acr_regs_pkg::GAIN_CAL_RESET;
  end

  // ----------------------------------------------------------------------
  // Channel pair selection
  // ----------------------------------------------------------------------
  // Out-of-range aux gain codes fall back to gain 1 rather than an
  // unmapped pair, so the datapath never sees an undefined calibration.
  always_comb begin
    auxIndex = (auxGainSel < acr_regs_pkg::AUX_GAIN_STEPS) ? auxGainSel
                                                           : 3'h0;
    case (channelSel)
      2'h0:    pairSel = 3'h0;
      2'h1:    pairSel = 3'h1;
      2'h2:    pairSel = 3'h2;
      2'h3:    pairSel = acr_regs_pkg::AUX_BASE_PAIR + auxIndex;
      default: pairSel = 3'h0;
    endcase
  end

  assign unlocked = (state.unlockKey == acr_regs_pkg::UNLOCK_KEY_VALUE);

  // ----------------------------------------------------------------------
  // Correction datapath
  // ----------------------------------------------------------------------
  // Result is scaled to quarter LSBs so the offset adds without rounding;
  // the product is shifted back and clipped to the unsigned result range.
  always_comb begin
    sumVal = $signed({1'b0, rawResult, 2'b00})
           + $signed({{4{state.activeOffset[14]}},
                      state.activeOffset});
    productVal = 35'(sumVal)
               * 35'($signed({1'b0, state.activeGain}));
    scaledVal = productVal >>> acr_regs_pkg::CORR_SHIFT;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.readData = 32'h0000_0000;

    // Writes
    if (regWrite) begin
      case (regAddr)
        acr_regs_pkg::REPEAT_CTRL_ADDR: begin
          next_state.repeatCount = regWriteData[
            acr_regs_pkg::REPEAT_CNT_LSB +:
            acr_regs_pkg::REPEAT_CNT_W];
          next_state.repeatEnable =
            regWriteData[acr_regs_pkg::REPEAT_EN_BIT];
        end
        acr_regs_pkg::BUFFER_CFG_ADDR: begin
          next_state.stagePowerDown = regWriteData[
            acr_regs_pkg::POWER_DOWN_LSB +:
            acr_regs_pkg::POWER_DOWN_W];
          next_state.choppingOffBits = regWriteData[
            acr_regs_pkg::CHOP_OFF_LSB +: acr_regs_pkg::CHOP_OFF_W];
        end
        acr_regs_pkg::UNLOCK_KEY_ADDR: begin
          next_state.unlockKey = regWriteData;
        end
        default: begin
          // Locked calibration writes fall through with no effect
          for (int i = 0; i < acr_regs_pkg::CAL_PAIRS; i++) begin
            if (unlocked &&
                regAddr == acr_regs_pkg::OFFSET_CAL_ADDR[i]) begin
              next_state.offsetCal[i] =
                regWriteData[acr_regs_pkg::CAL_W-1:0];
            end
            if (unlocked &&
                regAddr == acr_regs_pkg::GAIN_CAL_ADDR[i]) begin
              next_state.gainCal[i] =
                regWriteData[acr_regs_pkg::CAL_W-1:0];
            end
          end
        end
      endcase
    end

    // Reads; unmapped and reserved bits return zero
    if (regRead) begin
      case (regAddr)
        acr_regs_pkg::REPEAT_CTRL_ADDR: begin
          next_state.readData[acr_regs_pkg::REPEAT_CNT_LSB +:
            acr_regs_pkg::REPEAT_CNT_W] = state.repeatCount;
          next_state.readData[acr_regs_pkg::REPEAT_EN_BIT] =
            state.repeatEnable;
        end
        acr_regs_pkg::BUFFER_CFG_ADDR: begin
          next_state.readData = acr_regs_pkg::BUFFER_CFG_FIXED;
          next_state.readData[acr_regs_pkg::POWER_DOWN_LSB +:
            acr_regs_pkg::POWER_DOWN_W] = state.stagePowerDown;
          next_state.readData[acr_regs_pkg::CHOP_OFF_LSB +:
            acr_regs_pkg::CHOP_OFF_W] = state.choppingOffBits;
        end
        acr_regs_pkg::UNLOCK_KEY_ADDR: begin
          next_state.readData = state.unlockKey;
        end
        default: begin
          for (int i = 0; i < acr_regs_pkg::CAL_PAIRS; i++) begin
            if (regAddr == acr_regs_pkg::OFFSET_CAL_ADDR[i]) begin
              next_state.readData = {17'h0_0000,
                                     state.offsetCal[i]};
            end
            if (regAddr == acr_regs_pkg::GAIN_CAL_ADDR[i]) begin
              next_state.readData = {17'h0_0000,
                                     state.gainCal[i]};
            end
          end
        end
      endcase
    end

    // Pair for the channel in use, one cycle behind the selects
    next_state.activeOffset = state.offsetCal[pairSel];
    next_state.activeGain = state.gainCal[pairSel];

    // Corrected result; a zero gain gives a zero product
    next_state.resultValid = rawValid;
    if (rawValid) begin
      if (scaledVal < 0) begin
        next_state.result = 16'h0000;
      end else if (scaledVal > 35'sh0_0000_FFFF) begin
        next_state.result = 16'hFFFF;
      end else begin
        next_state.result = scaledVal[15:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= resetState;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign regReadData      = state.readData;
  assign repeatEnable     = state.repeatEnable;
  assign repeatCount      = state.repeatCount;
  assign stagePowerDown   = state.stagePowerDown;
  assign choppingOffBits  = state.choppingOffBits;
  assign calUnlocked      = unlocked;
  assign activeOffset     = state.activeOffset;
  assign activeGain       = state.activeGain;
  assign conversionResult = state.result;
  assign conversionValid  = state.resultValid;

endmodule : acr_regs

// ---- tb/acr_regs_assertions.sv ----
`timescale 1ns/1ps
module acr_regs_assertions (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [15:0] regAddr,
  input wire logic [31:0] regWriteData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regReadData,
  input wire logic        repeatEnable,
  input wire logic [7:0]  repeatCount,
  input wire logic [4:0]  stagePowerDown,
  input wire logic [3:0]  choppingOffBits,
  input wire logic        calUnlocked,
  input wire logic [1:0]  channelSel,
  input wire logic [14:0] activeGain,
  input wire logic        rawValid,
  input wire logic        conversionValid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Locked write to the low power gain
  // ----------------------------------------
  sequence seqLockedWr;
    !calUnlocked && regWrite && !$past(regWrite) && regAddr == 16'h228C
      && channelSel == 2'h0 && $stable(channelSel);
  endsequence
  sequence seqQuiet;
    !regWrite && channelSel == 2'h0;
  endsequence
  AST_LOCKED_HOLD: assert property (seqLockedWr ##1 seqQuiet |=>
    activeGain == $past(activeGain, 2)) else $error("locked write landed");
  AST_READ_IDLE: assert property (!$past(regRead) |->
    regReadData == 32'h0) else $error("read data outside read slot");
  AST_CONV_PULSE: assert property (
    conversionValid == $past(rawValid))
    else $error("result valid not one cycle after raw");
  AST_UNLOCK: assert property (regWrite && regAddr == 16'h2230
    && regWriteData == 32'hDE87A5AF |=> calUnlocked) else $error("no unlock");
  AST_RELOCK: assert property (regWrite && regAddr == 16'h2230
    && regWriteData != 32'hDE87A5AF |=> !calUnlocked) else $error("no lock");
  AST_REPEAT_WR: assert property (
    regWrite && regAddr == 16'h21F0 |=>
    repeatEnable == $past(regWriteData[0])
    && repeatCount == $past(regWriteData[11:4])) else $error("repeat fields");
  AST_BUFFER_WR: assert property (
    regWrite && regAddr == 16'h238C |=>
    stagePowerDown == $past(regWriteData[8:4])
    && choppingOffBits == $past(regWriteData[3:0]))
    else $error("buffer fields");
  AST_KEY_READ: assert property (
    regRead && regAddr == 16'h2230 && calUnlocked
    |=> regReadData == 32'hDE87A5AF) else $error("key readback");
  AST_REPEAT_RSVD: assert property (
    regRead && regAddr == 16'h21F0 |=>
    regReadData[31:12] == 20'h0 && regReadData[3:1] == 3'h0)
    else $error("repeat reserved bits");
  AST_CAL_RSVD: assert property (
    regRead && regAddr == 16'h228C |=> regReadData[31:15] == 17'h0_0000)
    else $error("calibration reserved bits");
endmodule : acr_regs_assertions

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [15:0] regAddr = 16'h0, rawResult = 16'h0;
  logic [31:0] regWriteData = 32'h0, regReadData;
  logic repeatEnable, calUnlocked, rawValid = 1'b0, conversionValid;
  logic [7:0] repeatCount;
  logic [4:0] stagePowerDown;
  logic [3:0] choppingOffBits;
  logic [1:0] channelSel = 2'h0;
  logic [2:0] auxGainSel = 3'h0;
  logic [14:0] activeOffset, activeGain;
  logic [15:0] conversionResult;
  int n_mismatch = 0, num_checks = 0;
  logic [15:0] rowA [10] = '{16'h21F0, 16'h21F0, 16'h238C, 16'h238C, 16'h2230,
    16'h228C, 16'h2234, 16'h2000, 16'h2230, 16'h228C};
  logic [31:0] rowD [10] = '{32'hFFFFFFFF, 32'h00000010, 32'hFFFFFFFF,
    32'h005F3D0F, 32'h12345678, 32'h00001234, 32'h00000055, 32'hFFFFFFFF,
    32'hDE87A5AF, 32'hFFFF8001};
  logic [31:0] rowE [10] = '{32'h00000FF1, 32'h00000010, 32'h005F3DFF,
    32'h005F3D0F, 32'h12345678, 32'h00004000, 32'h00000000, 32'h00000000,
    32'hDE87A5AF, 32'h00000001};
  always #50 ref_clk = ~ref_clk;
  acr_regs uut (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .repeatEnable(repeatEnable),
    .repeatCount(repeatCount), .stagePowerDown(stagePowerDown),
    .choppingOffBits(choppingOffBits), .calUnlocked(calUnlocked),
    .channelSel(channelSel), .auxGainSel(auxGainSel),
    .activeOffset(activeOffset), .activeGain(activeGain),
    .rawResult(rawResult), .rawValid(rawValid),
    .conversionResult(conversionResult), .conversionValid(conversionValid));
  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Leaves the strobe up so a following access can reuse the slot
  task automatic acc(logic w, logic r, logic [15:0] a, logic [31:0] d);
    regWrite <= w;
    regRead <= r;
    regAddr <= a;
    regWriteData <= d;
    @(posedge ref_clk);
  endtask : acc
  task automatic rd(logic [15:0] a, logic [31:0] exp);
    acc(1'b0, 1'b1, a, 32'h0);
    regRead <= 1'b0;
    @(negedge ref_clk);
    chk("read data", exp, regReadData);
    @(posedge ref_clk);
  endtask : rd
  task automatic conv(logic [15:0] raw, logic [15:0] exp);
    rawValid <= 1'b1;
    rawResult <= raw;
    @(posedge ref_clk);
    rawValid <= 1'b0;
    @(negedge ref_clk);
    chk("conversion valid", 32'h1, {31'h0, conversionValid});
    chk("conversion result", {16'h0, exp},
      {16'h0, conversionResult});
    @(posedge ref_clk);
  endtask : conv
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    rd(16'h21F0, 32'h00000160);
    rd(16'h238C, 32'h005F3D00);
    rd(16'h2230, 32'h00000000);
    for (int p = 0; p < 8; p++) begin
      rd(acr_regs_pkg::OFFSET_CAL_ADDR[p], 32'h0);
      rd(acr_regs_pkg::GAIN_CAL_ADDR[p], 32'h4000);
    end
    $display("reset values done");
    for (int i = 0; i < 10; i++) begin
      acc(1'b1, 1'b0, rowA[i], rowD[i]);
      rd(rowA[i], rowE[i]);
    end
    $display("register rows done");
    for (int p = 0; p < 8; p++) begin
      acc(1'b1, 1'b0, acr_regs_pkg::OFFSET_CAL_ADDR[p], 32'(p * 4 + 4));
      acc(1'b1, 1'b0, acr_regs_pkg::GAIN_CAL_ADDR[p], 32'(p + 32'h2000));
      rd(acr_regs_pkg::OFFSET_CAL_ADDR[p], 32'(p * 4 + 4));
      channelSel <= (p < 3) ? 2'(p) : 2'h3;
      auxGainSel <= (p < 3) ? 3'h0 : 3'(p - 3);
      acc(1'b0, 1'b0, 16'h0, 32'h0);
      acc(1'b0, 1'b0, 16'h0, 32'h0);
      @(negedge ref_clk);
      chk("active offset", 32'(p * 4 + 4), {17'h0, activeOffset});
      chk("active gain", 32'(p + 32'h2000), {17'h0, activeGain});
      @(posedge ref_clk);
    end
    // Unmapped aux gain codes fall back to the gain 1 pair
    channelSel <= 2'h3;
    auxGainSel <= 3'h7;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("fallback offset", 32'h10, {17'h0, activeOffset});
    chk("fallback gain", 32'h2003, {17'h0, activeGain});
    @(posedge ref_clk);
    channelSel <= 2'h0;
    auxGainSel <= 3'h0;
    repeat (2) @(posedge ref_clk);
    conv(16'h1234, 16'h091A);
    acc(1'b1, 1'b0, 16'h228C, 32'h0);
    repeat (2) acc(1'b0, 1'b0, 16'h0, 32'h0);
    conv(16'h1234, 16'h0000);
    acc(1'b1, 1'b0, 16'h2230, 32'h0);
    acc(1'b1, 1'b0, 16'h2288, 32'h7FFF);
    rd(16'h2288, 32'h4);
    $display("calibration done");
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk("count", 32'h16, {24'h0, repeatCount});
    chk("power down", 32'h10, {27'h0, stagePowerDown});
    chk("unlocked", 32'h0, {31'h0, calUnlocked});
    chk("gain", 32'h4000, {17'h0, activeGain});
    chk("chop off", 32'h0, {28'h0, choppingOffBits});
    @(posedge ref_clk);
    rd(16'h238C, 32'h005F3D00);
    rd(16'h2288, 32'h0);
    rd(16'h228C, 32'h4000);
    $display("mid-run reset done");
    end_sim();
  end
endmodule : tb_top
bind acr_regs acr_regs_assertions chk_i (.ref_clk(ref_clk), .reset(reset),
  .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
  .regRead(regRead), .regReadData(regReadData), .repeatEnable(repeatEnable),
  .repeatCount(repeatCount), .stagePowerDown(stagePowerDown),
  .choppingOffBits(choppingOffBits), .calUnlocked(calUnlocked),
  .channelSel(channelSel), .activeGain(activeGain), .rawValid(rawValid),
  .conversionValid(conversionValid));
